//--- shared/cdi_pkg.sv
// Package with constants, rate table and types for the clock detect block.
package cdi_pkg;

    // Register offsets on the control port.
    localparam logic [7:0] RATE_OFFS     = 8'h3F;
    localparam logic [7:0] RATIO_HI_OFFS = 8'h40;
    localparam logic [7:0] RATIO_LO_OFFS = 8'h41;
    localparam logic [7:0] CFG_OFFS      = 8'h42;
    localparam logic [7:0] LATCH_OFFS    = 8'h2C;

    // Values after reset.
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] STS_RST = 8'h00;

    // Field positions and widths.
    localparam int RATE_LSB   = 2;
    localparam int RATE_W     = 6;
    localparam int RATIO_HI_W = 6;
    localparam int RATIO_LO_W = 8;
    localparam int RATIO_W    = 14;
    localparam int NUM_FLAGS  = 8;
    localparam int NUM_RATES  = 40;
    localparam int PER_W      = 17;
    localparam int CNT_W      = 19;
    localparam logic [PER_W-1:0] PER_MAX = 17'h1FFFF;

    // Timing: the interrupt pulse width and the core clock rate.
    localparam longint CLK_HZ         = 125000000;
    localparam longint PULSE_MS       = 2;
    localparam longint PULSE_CYC_DFLT = CLK_HZ * PULSE_MS / 1000;

    // Frame rate windows in Hz; entry k stands for code k+1.
    localparam longint RATE_LO [0:NUM_RATES-1] = '{
        670320, 536256, 446880, 383040, 335160, 297920, 268128, 223440,
        191520, 167580, 148960, 134064, 111720, 95760, 83790, 74480,
        67032, 55860, 47880, 41895, 37240, 33516, 27930, 23940, 20947,
        18620, 16758, 13965, 11970, 10473, 9310, 8379, 6982, 5985, 5236,
        4655, 4189, 3491, 2992, 2618};
    localparam longint RATE_HI [0:NUM_RATES-1] = '{
        791040, 632832, 527360, 452022, 395520, 351573, 316416, 263680,
        226011, 197760, 175786, 158208, 131840, 113005, 98880, 87893,
        79104, 65920, 56502, 49440, 43946, 39552, 32960, 28251, 24720,
        21973, 19776, 16480, 14125, 12360, 10986, 9888, 8240, 7062, 6180,
        5493, 4944, 4120, 3531, 3090};

    typedef enum logic [1:0] {
        EV_LATCHED  = 2'b00,
        EV_LIVE     = 2'b01,
        EV_PERIODIC = 2'b10,
        EV_ONESHOT  = 2'b11
    } cdi_event_e;

    typedef enum logic [1:0] {
        PD_NONE     = 2'b00,
        PD_UNMASKED = 2'b01,
        PD_ALL      = 2'b10,
        PD_RSVD     = 2'b11
    } cdi_pdsel_e;

    // Interrupt configuration, laid out as the register bits 7 down to 0.
    typedef struct packed {
        logic       pol;
        cdi_event_e style;
        cdi_pdsel_e pdsel;
        logic       filter;
        logic       recovery;
        logic       clr_all;
    } cdi_cfg_s;

endpackage

//--- hw/cdi_rate_meter.sv
// Frame rate meter for the secondary audio port frame sync.
`timescale 1ns/1ps
module cdi_rate_meter (
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  wire logic                      fs_pin,
    output logic [cdi_pkg::RATE_W-1:0]     rate_code
);
    logic                         fs_s1_r;
    logic                         fs_s2_r;
    logic                         fs_s3_r;
    logic                         seen_r;
    logic [cdi_pkg::PER_W-1:0]    cnt_r;
    logic [cdi_pkg::RATE_W-1:0]   code_r;
    logic [cdi_pkg::RATE_W-1:0]   code_nxt;
    logic [cdi_pkg::NUM_RATES-1:0] hit;
    logic [63:0]                  per64;
    logic                         fs_rise;

    // Two flops before the pin is used; edge detection looks at stage two.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fs_s1_r <= 1'b0;
            fs_s2_r <= 1'b0;
            fs_s3_r <= 1'b0;
        end else begin
            fs_s1_r <= fs_pin;
            fs_s2_r <= fs_s1_r;
            fs_s3_r <= fs_s2_r;
        end
    end

    assign fs_rise = fs_s2_r & ~fs_s3_r;
    assign per64   = 64'(cnt_r) + 64'h1;

    // Each window is checked as lo*period <= clk <= hi*period, no divider.
    genvar k;
    generate
        for (k = 0; k < cdi_pkg::NUM_RATES; k++) begin : g_win
            assign hit[k] = (64'(cdi_pkg::RATE_LO[k]) * per64
                             <= 64'(cdi_pkg::CLK_HZ))
                         && (64'(cdi_pkg::RATE_HI[k]) * per64
                             >= 64'(cdi_pkg::CLK_HZ));
        end
    endgenerate

    // Windows overlap; the slower rate (higher code) wins, since each
    // nominal rate sits at the low end of the next faster window.
    always_comb begin
        code_nxt = '0;
        for (int i = 0; i < cdi_pkg::NUM_RATES; i++) begin
            if (hit[i]) begin
                code_nxt = 6'(i + 1);
            end
        end
    end

    // Period counter; the first edge only starts timing, a stall reads 0.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r  <= '0;
            seen_r <= 1'b0;
            code_r <= '0;
        end else if (fs_rise) begin
            cnt_r  <= '0;
            seen_r <= 1'b1;
            if (seen_r) begin
                code_r <= code_nxt;
            end
        end else if (cnt_r != cdi_pkg::PER_MAX) begin
            cnt_r <= cnt_r + 17'h00001;
        end else begin
            code_r <= '0;
        end
    end

    assign rate_code = code_r;

    AST_RATE_VALID: assert property (@(posedge core_clk) disable iff (rst)
        code_r <= 6'h28)
        else $error("Reserved rate code produced.");

    AST_RATE_STALL: assert property (@(posedge core_clk) disable iff (rst)
        (cnt_r == cdi_pkg::PER_MAX && !fs_rise) |=> code_r == 6'h00)
        else $error("Rate code kept after frame sync stopped.");

endmodule // cdi_rate_meter

//--- hw/cdi_pulse_timer.sv
// Timer for the periodic and single-shot interrupt pulses.
`timescale 1ns/1ps
module cdi_pulse_timer #(
    parameter logic [cdi_pkg::CNT_W-1:0] PULSE_CYC =
        cdi_pkg::CNT_W'(cdi_pkg::PULSE_CYC_DFLT)
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic periodic,
    input  wire logic run,
    input  wire logic trig,
    output logic      active
);
    localparam logic [cdi_pkg::CNT_W-1:0] ONE = 19'h00001;

    logic [cdi_pkg::CNT_W-1:0] per_r;
    logic [cdi_pkg::CNT_W-1:0] shot_r;

    // Periodic phase: on for the first pulse width, off for the second.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            per_r <= '0;
        end else if (!run) begin
            per_r <= '0;
        end else if (per_r == (PULSE_CYC << 1) - ONE) begin
            per_r <= '0;
        end else begin
            per_r <= per_r + ONE;
        end
    end

    // Single shot; an event during a pulse merges into the running pulse.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            shot_r <= '0;
        end else if (trig && shot_r == '0) begin
            shot_r <= PULSE_CYC;
        end else if (shot_r != '0) begin
            shot_r <= shot_r - ONE;
        end
    end

    assign active = periodic ? (run && per_r < PULSE_CYC)
                             : (shot_r != '0);

    sequence s_shot_start;
        !periodic && trig && shot_r == '0;
    endsequence

    AST_SHOT_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        s_shot_start ##1 !periodic |-> active [*8])
        else $error("Single interrupt pulse ended early.");

    AST_PER_OFF: assert property (@(posedge core_clk) disable iff (rst)
        (periodic && run && per_r == PULSE_CYC) |-> !active)
        else $error("Periodic pulse active in its off half.");

endmodule // cdi_pulse_timer

//--- hw/cdi_clock_detect_irq.sv
// Clock detect status and interrupt configuration block, top level.
//
// Overview of operation
// - Secondary port rate shows as 6-bit code in bits 7-2; 0, 41-63 unused.
// - Frame rate 670320 to 791040 Hz reads code 1 (768 kHz).
// - Frame rate 83790 to 98880 Hz reads code 15 (96 kHz); the meter reads 83790 to 87893 Hz as code 16.
// - Frame rate 41895 to 49440 Hz reads code 20 (48 kHz); the meter reads 41895 to 43946 Hz as code 21.
// - Frame rate 2618 to 3090 Hz reads code 40 (3 kHz).
// - Upper six ratio bits read in bits 5-0 of the high register.
// - Lower eight ratio bits read as the whole low register.
// - Polarity bit 0 drives interrupt active low, 1 active high.
// - Style 0: interrupt held while any unmasked latched flag is set.
// - Style 1: interrupt follows unmasked live conditions.
// - Style 2: 2 ms active in every 4 ms while unmasked latch set.
// - Style 3: one 2 ms pulse per unmasked event; events that start while a pulse runs give no new pulse.
// - Power-down selector: none, unmasked faults, all faults, reserved.
// - Readback filter 0 shows all latched flags, 1 only unmasked.
// - Recovery 0 re-powers channels after fault; 1 keeps them down.
// - Clear policy 0: read clears a latch only if live is zero.
// - Clear policy 1: read clears latches whatever the live state.
// - Reserved bits read zero; host writes only reset values there.
`timescale 1ns/1ps
module cdi_clock_detect_irq #(
    parameter logic [cdi_pkg::CNT_W-1:0] PULSE_CYC =
        cdi_pkg::CNT_W'(cdi_pkg::PULSE_CYC_DFLT)
) (
    input  wire logic                            core_clk,
    input  wire logic                            rst,
    input  wire logic [7:0]                      reg_addr,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    input  wire logic [7:0]                      reg_wdata,
    output logic [7:0]                           reg_rdata,
    input  wire logic                            sec_fs_pin,
    input  wire logic [cdi_pkg::RATIO_W-1:0]     ratio_value,
    input  wire logic                            ratio_load,
    input  wire logic [cdi_pkg::NUM_FLAGS-1:0]   irq_live,
    input  wire logic [cdi_pkg::NUM_FLAGS-1:0]   irq_mask,
    input  wire logic                            pd_release,
    output logic                                 chan_pd,
    output logic                                 irq_out
);
    localparam int NF = cdi_pkg::NUM_FLAGS;

    cdi_pkg::cdi_cfg_s              cfg_r;
    logic [cdi_pkg::RATE_W-1:0]     rate_code;
    logic [cdi_pkg::RATIO_W-1:0]    ratio_r;
    logic [cdi_pkg::RATIO_LO_W-1:0] ratio_lo_hold_r;
    logic [NF-1:0]                  live_q_r;
    logic [NF-1:0]                  latch_r;
    logic [NF-1:0]                  latch_nxt;
    logic [NF-1:0]                  rise;
    logic [NF-1:0]                  visible;
    logic [NF-1:0]                  clr;
    logic                           rd_latch;
    logic                           any_latched;
    logic                           any_live;
    logic                           any_event;
    logic                           pulse_active;
    logic                           irq_act;
    logic                           pd_req;
    logic                           chan_pd_r;
    logic                           irq_out_r;
    logic [7:0]                     rdata_r;
    logic [7:0]                     rdata_nxt;

    // Frame rate measurement of the secondary audio port.
    cdi_rate_meter u_meter (
        .core_clk  (core_clk),
        .rst       (rst),
        .fs_pin    (sec_fs_pin),
        .rate_code (rate_code)
    );

    // Configuration register; all eight bits are writable.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_r <= cdi_pkg::CFG_RST;
        end else if (reg_wr && reg_addr == cdi_pkg::CFG_OFFS) begin
            cfg_r <= reg_wdata;
        end
    end

    // The whole ratio is captured at once so both halves stay paired.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ratio_r <= '0;
        end else if (ratio_load) begin
            ratio_r <= ratio_value;
        end
    end

    // Reading the high half freezes the low half for the read that follows.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ratio_lo_hold_r <= '0;
        end else if (reg_rd && reg_addr == cdi_pkg::RATIO_HI_OFFS) begin
            ratio_lo_hold_r <= ratio_r[cdi_pkg::RATIO_LO_W-1:0];
        end
    end

    // Event edges of the live conditions drive the latches.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            live_q_r <= '0;
        end else begin
            live_q_r <= irq_live;
        end
    end

    assign rise     = irq_live & ~live_q_r;
    assign rd_latch = reg_rd && reg_addr == cdi_pkg::LATCH_OFFS;
    assign visible  = cfg_r.filter ? (latch_r & ~irq_mask) : latch_r;

    // Only what the read shows is cleared; a new edge in the same cycle
    // wins so an event is never lost to a racing read.
    always_comb begin
        clr = '0;
        if (rd_latch) begin
            if (cfg_r.clr_all) begin
                clr = visible;
            end else begin
                clr = visible & ~irq_live;
            end
        end
        latch_nxt = (latch_r & ~clr) | rise;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            latch_r <= '0;
        end else begin
            latch_r <= latch_nxt;
        end
    end

    assign any_latched = |(latch_r & ~irq_mask);
    assign any_live    = |(irq_live & ~irq_mask);
    assign any_event   = |(rise & ~irq_mask);

    // Pulse timing for the periodic and one-shot styles.
    cdi_pulse_timer #(
        .PULSE_CYC (PULSE_CYC)
    ) u_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .periodic (cfg_r.style == cdi_pkg::EV_PERIODIC),
        .run      (any_latched),
        .trig     (any_event),
        .active   (pulse_active)
    );

    // Interrupt source selection by event style.
    always_comb begin
        case (cfg_r.style)
            cdi_pkg::EV_LATCHED:  irq_act = any_latched;
            cdi_pkg::EV_LIVE:     irq_act = any_live;
            cdi_pkg::EV_PERIODIC: irq_act = pulse_active;
            cdi_pkg::EV_ONESHOT:  irq_act = pulse_active;
            default:              irq_act = 1'b0;
        endcase
    end

    // The pin is registered so polarity changes never glitch it.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_out_r <= 1'b1;
        end else begin
            irq_out_r <= cfg_r.pol ? irq_act : ~irq_act;
        end
    end

    // Faults that may power the channels down, by selector.
    always_comb begin
        case (cfg_r.pdsel)
            cdi_pkg::PD_UNMASKED: pd_req = any_live;
            cdi_pkg::PD_ALL:      pd_req = |irq_live;
            default:              pd_req = 1'b0;
        endcase
    end

    // Manual recovery waits for an explicit release once the fault is gone.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chan_pd_r <= 1'b0;
        end else if (pd_req) begin
            chan_pd_r <= 1'b1;
        end else if (!cfg_r.recovery || pd_release) begin
            chan_pd_r <= 1'b0;
        end
    end

    // Read data mux; reserved bits and unmapped addresses return zero.
    always_comb begin
        case (reg_addr)
            cdi_pkg::RATE_OFFS:
                rdata_nxt = {rate_code, 2'b00};
            cdi_pkg::RATIO_HI_OFFS:
                rdata_nxt = {2'b00, ratio_r[cdi_pkg::RATIO_W-1:
                             cdi_pkg::RATIO_LO_W]};
            cdi_pkg::RATIO_LO_OFFS:
                rdata_nxt = ratio_lo_hold_r;
            cdi_pkg::CFG_OFFS:
                rdata_nxt = cfg_r;
            cdi_pkg::LATCH_OFFS:
                rdata_nxt = visible;
            default:
                rdata_nxt = cdi_pkg::STS_RST;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= cdi_pkg::STS_RST;
        end else if (reg_rd) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign chan_pd   = chan_pd_r;
    assign irq_out   = irq_out_r;

    sequence s_cfg_steady;
        $stable(cfg_r);
    endsequence

    sequence s_high_then_low;
        reg_rd && reg_addr == cdi_pkg::RATIO_HI_OFFS
        ##1 reg_rd && reg_addr == cdi_pkg::RATIO_LO_OFFS;
    endsequence

    AST_LATCHED_LEVEL: assert property (@(posedge core_clk) disable iff (rst)
        (cfg_r.style == cdi_pkg::EV_LATCHED && any_latched) and s_cfg_steady
        |=> irq_out == $past(cfg_r.pol))
        else $error("Latched style interrupt not asserted.");

    AST_LIVE_FOLLOW: assert property (@(posedge core_clk) disable iff (rst)
        (cfg_r.style == cdi_pkg::EV_LIVE && !any_live) and s_cfg_steady
        |=> irq_out != $past(cfg_r.pol))
        else $error("Live style interrupt active with no live condition.");

    AST_POL_IDLE: assert property (@(posedge core_clk) disable iff (rst)
        (!irq_act && cfg_r.pol == 1'b0) |=> irq_out == 1'b1)
        else $error("Active low interrupt not idle high.");

    AST_LATCH_SET: assert property (@(posedge core_clk) disable iff (rst)
        rise[0] |=> latch_r[0] [*2] or (latch_r[0] ##1 $past(rd_latch)))
        else $error("Latch missed its event.");

    AST_CLR_LIVE: assert property (@(posedge core_clk) disable iff (rst)
        (rd_latch && !cfg_r.clr_all && irq_live[0] && latch_r[0])
        |=> latch_r[0])
        else $error("Latch cleared while live condition present.");

    AST_CLR_ALL: assert property (@(posedge core_clk) disable iff (rst)
        (rd_latch && cfg_r.clr_all && !cfg_r.filter && !rise[0])
        |=> !latch_r[0])
        else $error("Latch not cleared by read.");

    AST_FILTER: assert property (@(posedge core_clk) disable iff (rst)
        (rd_latch && cfg_r.filter) |=> reg_rdata == $past(latch_r & ~irq_mask))
        else $error("Masked flag shown in filtered readback.");

    AST_RSVD_ZERO: assert property (@(posedge core_clk) disable iff (rst)
        (reg_rd && reg_addr == cdi_pkg::RATE_OFFS) |=> reg_rdata[1:0] == 2'b00)
        else $error("Reserved rate bits read nonzero.");

    AST_TORN: assert property (@(posedge core_clk) disable iff (rst)
        s_high_then_low |=> reg_rdata == $past(ratio_r[7:0], 2))
        else $error("Ratio low byte torn from high byte.");

    AST_PD_ALL: assert property (@(posedge core_clk) disable iff (rst)
        (cfg_r.pdsel == cdi_pkg::PD_ALL && |irq_live) |=> chan_pd)
        else $error("Fault did not power channels down.");

    AST_MANUAL_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        (chan_pd && cfg_r.recovery && !pd_release) |=> chan_pd)
        else $error("Channels re-powered under manual recovery.");

    AST_RATIO_HI: assert property (
        @(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == cdi_pkg::RATIO_HI_OFFS
        |=> reg_rdata == {2'b00, $past(ratio_r[13:8])})
        else $error("Ratio high byte read wrong.");

    AST_LO_SNAP: assert property (
        @(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == cdi_pkg::RATIO_HI_OFFS
        |=> ratio_lo_hold_r == $past(ratio_r[7:0]))
        else $error("Low ratio byte not frozen with the high byte.");

    AST_RATE_READ: assert property (
        @(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == cdi_pkg::RATE_OFFS
        |=> reg_rdata[7:2] == $past(rate_code))
        else $error("Rate code read wrong.");

    AST_LIVE_ON: assert property (
        @(posedge core_clk) disable iff (rst)
        cfg_r.style == cdi_pkg::EV_LIVE && any_live
        |=> irq_out == $past(cfg_r.pol))
        else $error("Live style interrupt missed a live condition.");

    AST_AUTO_RECOVER: assert property (
        @(posedge core_clk) disable iff (rst)
        chan_pd && !cfg_r.recovery && !pd_req |=> !chan_pd)
        else $error("Channels not re-powered under auto recovery.");

endmodule // cdi_clock_detect_irq

//--- tb/cdi_fs_source.sv
// Frame sync source that stands in for the secondary audio port master.
`timescale 1ns/1ps
module cdi_fs_source (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [31:0] period,
    output logic             fs
);
    logic [31:0] cnt_r;

    // Square wave of the given period in core cycles, high for half of it.
    // A zero period parks the line low, since a halted master drives no sync.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst || period == 32'h0) begin
            cnt_r <= 32'h0;
            fs    <= 1'b0;
        end else begin
            cnt_r <= (cnt_r >= period - 32'h1) ? 32'h0 : cnt_r + 32'h1;
            fs    <= (cnt_r < period / 32'h2);
        end
    end
endmodule // cdi_fs_source

//--- tb/test_clock_detect_irq_config.sv
// Self-checking bench for the clock detect and interrupt config block.
`timescale 1ns/1ps
module test_clock_detect_irq_config;
    localparam int PC    = 16;
    localparam int LIMIT = 70000;
    logic        core_clk    = 1'b0;
    logic        rst         = 1'b1;
    logic [7:0]  reg_addr    = 8'h00;
    logic        reg_wr      = 1'b0;
    logic        reg_rd      = 1'b0;
    logic [7:0]  reg_wdata   = 8'h00;
    logic [7:0]  reg_rdata;
    logic        sec_fs_pin;
    logic [13:0] ratio_value = 14'h0000;
    logic        ratio_load  = 1'b0;
    logic [7:0]  irq_live    = 8'h00;
    logic [7:0]  irq_mask    = 8'h00;
    logic        pd_release  = 1'b0;
    logic        chan_pd;
    logic        irq_out;
    logic [31:0] fs_period   = 32'h0;
    int          miscompares = 0;
    int          check_count = 0;
    int          cycles      = 0;
    int          per [4]     = '{41667, 163, 1302, 2604};
    logic [5:0]  code [4]    = '{6'h28, 6'h01, 6'h0F, 6'h14};

    cdi_clock_detect_irq #(.PULSE_CYC(cdi_pkg::CNT_W'(PC))) dut (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .sec_fs_pin(sec_fs_pin),
        .ratio_value(ratio_value), .ratio_load(ratio_load),
        .irq_live(irq_live), .irq_mask(irq_mask),
        .pd_release(pd_release), .chan_pd(chan_pd), .irq_out(irq_out));

    cdi_fs_source fs_src (
        .core_clk(core_clk), .rst(rst), .period(fs_period),
        .fs(sec_fs_pin));

    // 125 MHz core clock.
    always #4 core_clk = ~core_clk;

    // Watchdog so that a hung test cannot stall the run.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // One-cycle write strobe, launched on a falling edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask

    // Read data is registered, so it is looked at one cycle after the strobe.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        chk(reg_rdata, exp);
    endtask

    task automatic ld(input logic [13:0] v);
        @(negedge core_clk);
        ratio_value = v;
        ratio_load  = 1'b1;
        @(negedge core_clk);
        ratio_load = 1'b0;
    endtask

    task automatic pin(input logic v, input logic exp);
        chk({7'h00, v}, {7'h00, exp});
    endtask

    task automatic live(input logic [7:0] v, input logic [7:0] m);
        @(negedge core_clk);
        irq_live = v;
        irq_mask = m;
    endtask

    // Counts high cycles of the interrupt pin over a window.
    task automatic hi_count(input int n, input logic [7:0] exp);
        int h = 0;
        repeat (n) begin
            @(negedge core_clk);
            h += int'(irq_out);
        end
        chk(8'(h), exp);
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        pin(irq_out, 1'b1);
        pin(chan_pd, 1'b0);
        for (int i = 0; i < 4; i++) rd(8'h3F + 8'(i), 8'h00);
        rd(8'h55, 8'h00);
        wr(8'h3F, 8'hFC);
        rd(8'h3F, 8'h00);
        done("reset");
        // Ratio halves pair up through the high byte read.
        ld(14'h2A5C);
        wr(8'h40, 8'h3F);
        rd(8'h40, 8'h2A);
        rd(8'h41, 8'h5C);
        ld(14'h3FFF);
        rd(8'h41, 8'h5C);
        rd(8'h40, 8'h3F);
        rd(8'h41, 8'hFF);
        // High then low read back to back; the low byte pairs with the high.
        ld(14'h1234);
        @(negedge core_clk);
        reg_addr = 8'h40;
        reg_rd   = 1'b1;
        @(negedge core_clk);
        reg_addr = 8'h41;
        chk(reg_rdata, 8'h12);
        @(negedge core_clk);
        reg_rd = 1'b0;
        chk(reg_rdata, 8'h34);
        done("ratio");
        // Latched style, active low; read clears once live is gone.
        wr(8'h42, 8'hA5);
        rd(8'h42, 8'hA5);
        wr(8'h42, 8'h00);
        live(8'h01, 8'h00);
        cyc(4);
        pin(irq_out, 1'b0);
        live(8'h00, 8'h00);
        cyc(4);
        pin(irq_out, 1'b0);
        rd(8'h2C, 8'h01);
        cyc(3);
        pin(irq_out, 1'b1);
        rd(8'h2C, 8'h00);
        done("latched");
        // Clear policy with the live condition still present.
        live(8'h02, 8'h00);
        cyc(3);
        rd(8'h2C, 8'h02);
        rd(8'h2C, 8'h02);
        wr(8'h42, 8'h01);
        rd(8'h2C, 8'h02);
        rd(8'h2C, 8'h00);
        done("clear policy");
        // Readback filter hides a masked flag, which also raises no interrupt.
        live(8'h04, 8'h04);
        wr(8'h42, 8'h04);
        cyc(3);
        pin(irq_out, 1'b1);
        rd(8'h2C, 8'h00);
        wr(8'h42, 8'h00);
        rd(8'h2C, 8'h04);
        live(8'h00, 8'h00);
        rd(8'h2C, 8'h04);
        rd(8'h2C, 8'h00);
        done("filter");
        // Live style, active high: the pin ignores the latch.
        wr(8'h42, 8'hA0);
        cyc(3);
        pin(irq_out, 1'b0);
        live(8'h08, 8'h00);
        cyc(3);
        pin(irq_out, 1'b1);
        live(8'h00, 8'h00);
        cyc(3);
        pin(irq_out, 1'b0);
        rd(8'h2C, 8'h08);
        // Periodic style: half of any two whole periods is active.
        wr(8'h42, 8'hC0);
        live(8'h10, 8'h00);
        hi_count(4 * PC, 8'(2 * PC));
        live(8'h00, 8'h00);
        rd(8'h2C, 8'h10);
        cyc(2 * PC);
        hi_count(2 * PC, 8'h00);
        // Single-shot style: one pulse per event although the latch stays.
        wr(8'h42, 8'hE0);
        live(8'h20, 8'h00);
        hi_count(4 * PC, 8'(PC));
        live(8'h00, 8'h00);
        rd(8'h2C, 8'h20);
        done("styles");
        // Fault power-down selection and recovery.
        wr(8'h42, 8'h08);
        live(8'h40, 8'h40);
        cyc(3);
        pin(chan_pd, 1'b0);
        live(8'hC0, 8'h40);
        cyc(3);
        pin(chan_pd, 1'b1);
        live(8'h40, 8'h40);
        cyc(3);
        pin(chan_pd, 1'b0);
        wr(8'h42, 8'h10);
        cyc(3);
        pin(chan_pd, 1'b1);
        wr(8'h42, 8'h12);
        live(8'h00, 8'h40);
        cyc(3);
        pin(chan_pd, 1'b1);
        @(negedge core_clk);
        pd_release = 1'b1;
        @(negedge core_clk);
        pd_release = 1'b0;
        cyc(3);
        pin(chan_pd, 1'b0);
        live(8'hFF, 8'h00);
        wr(8'h42, 8'h00);
        cyc(3);
        pin(chan_pd, 1'b0);
        wr(8'h42, 8'h18);
        cyc(3);
        pin(chan_pd, 1'b0);
        live(8'h00, 8'h00);
        wr(8'h42, 8'h01);
        rd(8'h2C, 8'hFF);
        done("power down");
        // Frame rates near nominal give their codes; the slowest goes first.
        for (int i = 0; i < 4; i++) begin
            fs_period = 32'(per[i]);
            cyc(i == 0 ? per[i] + 60 : 3 * per[i]);
            rd(8'h3F, {code[i], 2'b00});
        end
        done("rate");
        wrap_up();
    end
endmodule // test_clock_detect_irq_config
